// *** hw/sieb_pkg.sv ***
// constants, types and register layout of the system interrupt bank
// assumes one core clock domain and byte-wide special register access
package sieb_pkg;

  // ****************************************************************
  // register map and bit layout
  // ****************************************************************
  localparam logic [15:0] SFR_BASE = 16'h0000;
  localparam logic [15:0] SFR_LAST = 16'h000F;
  localparam logic [3:0] OFS_SYS_IRQ_ENABLE_A = 4'h0;
  localparam logic [3:0] OFS_SERIAL_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] OFS_SYS_IRQ_FLAGS_A = 4'h2;
  localparam logic [3:0] OFS_SERIAL_IRQ_FLAGS = 4'h3;

  // system enable bits
  localparam int BIT_WDOG_IRQ_EN = 0;
  localparam int BIT_OSC_FAULT_IRQ_EN = 1;
  localparam int BIT_PIN_NMI_IRQ_EN = 4;
  localparam int BIT_FLASH_VIOL_IRQ_EN = 5;
  // system flag bits
  localparam int BIT_WDOG_FLAG = 0;
  localparam int BIT_OSC_FAULT_FLAG = 1;
  localparam int BIT_POWER_ON_FLAG = 2;
  localparam int BIT_EXT_RESET_FLAG = 3;
  localparam int BIT_PIN_NMI_FLAG = 4;
  // serial enable and flag bits share positions
  localparam int BIT_UNIT_A_RX = 0;
  localparam int BIT_UNIT_A_TX = 1;
  localparam int BIT_UNIT_B_RX = 2;
  localparam int BIT_UNIT_B_TX = 3;

  // implemented bits of each register
  localparam logic [7:0] MASK_SYS_IRQ_ENABLE_A = 8'h33;
  localparam logic [7:0] MASK_SERIAL_IRQ_ENABLE = 8'h0F;
  localparam logic [7:0] MASK_SYS_IRQ_FLAGS_A = 8'h1F;
  localparam logic [7:0] MASK_SERIAL_IRQ_FLAGS = 8'h0F;

  // bits reloaded on every power-up clear, and their values
  localparam logic [7:0] PUC_MASK_SYS_FLAGS_A = 8'h12;
  localparam logic [7:0] PUC_VAL_SYS_FLAGS_A = 8'h02;
  localparam logic [7:0] PUC_VAL_SERIAL_FLAGS = 8'h0A;
  localparam logic [7:0] PUC_VAL_ENABLE = 8'h00;
  // power-on values
  localparam logic [7:0] POR_VAL_SYS_FLAGS_A = 8'h06;
  localparam logic [7:0] READ_FILL = 8'h00;

  // ****************************************************************
  // memory ranges that may hold code
  // ****************************************************************
  localparam logic [15:0] PERIPH_LAST = 16'h01FF;
  localparam logic [15:0] RAM_LAST = 16'h03FF;
  localparam logic [15:0] BOOT_FIRST = 16'h0C00;
  localparam logic [15:0] INFO_LAST = 16'h10FF;
  localparam logic [15:0] MAIN_FIRST = 16'hE000;

  // boot word patterns
  localparam logic [15:0] LOADER_OFF_KEY = 16'hAA55;
  localparam logic [15:0] LOADER_NO_ERASE_KEY = 16'h0000;
  localparam logic [15:0] BLANK_RESET_VECTOR = 16'hFFFF;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    SIEB_MODE_UART,
    SIEB_MODE_SPI,
    SIEB_MODE_I2C
  } sieb_ub_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sieb_sfr_req_t;

  typedef struct packed {
    logic overflow;
    logic key_viol;
    logic reset_mode;
  } sieb_wdog_ev_t;

  typedef struct packed {
    logic arb_lost_flag;
    logic no_ack_flag;
    logic start_seen_flag;
    logic stop_seen_flag;
  } sieb_i2c_stat_t;

endpackage

// *** hw/sieb_top.sv ***
// system interrupt enable and flag bank with reset source logic
// assumes the core drives byte accesses on the core clock and that
// rstn_i is the power-on reset; the reset/nmi pin is asynchronous
//
// Operation
// - reset on code fetch from peripheral/unused space
// - semi-maskable sources gated only by own enable
// - reset events ignore every enable
// - unit b receive vector per spi/i2c mode
// - unit b transmit vector per mode
// - loader disabled or erase blocked by key word
// - enable register 0: wdog, osc, nmi, flash
// - wdog enable only counts in interval mode
// - enable register 1: unit a/b rx, tx
// - wdog flag set by reset-mode overflow/key, cleared by pin
// - external reset flag set by reset pin
// - power-on flag one after power-on
// - osc flag one on clear; nmi flag from pin
// - serial flags: tx one, rx zero on clear
// - bracketed bits power-on only, plain on clear
// - absent bits read zero, ignore writes
// - registers decoded in lowest sixteen bytes
// - blank reset vector sends core to deepest sleep
`timescale 1ns/1ps

module sieb_top
  import sieb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire sieb_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic fetch_i,
  input wire logic [15:0] fetch_addr_i,
  input wire sieb_wdog_ev_t wdog_i,
  input wire logic osc_fault_i,
  input wire logic flash_viol_flag_i,
  input wire logic rst_nmi_pin_n_i,
  input wire logic pin_nmi_sel_i,
  input wire logic [3:0] unit_flag_set_i,
  input wire sieb_ub_mode_t unit_b_mode_i,
  input wire sieb_i2c_stat_t i2c_stat_i,
  input wire logic [15:0] loader_security_word_i,
  input wire logic [15:0] reset_vector_i,
  output logic sys_reset_o,
  output logic power_up_clear_o,
  output logic nmi_req_o,
  output logic wdog_irq_o,
  output logic rx_vec_req_o,
  output logic tx_vec_req_o,
  output logic loader_disabled_o,
  output logic loader_no_erase_o,
  output logic deepest_sleep_mode_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] sys_irq_enable_a;
    logic [7:0] serial_irq_enable;
    logic [7:0] sys_irq_flags_a;
    logic [7:0] serial_irq_flags;
    logic [7:0] rdata;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic power_up_clear;
    logic sys_reset;
    logic nmi_req;
    logic wdog_irq;
    logic rx_req;
    logic tx_req;
    logic ldr_dis;
    logic ldr_no_erase;
    logic sleep;
    logic boot_seen;
  } sieb_state_t;

  // power-on values; pin idles high
  localparam sieb_state_t ST_POR = '{
    sys_irq_enable_a: PUC_VAL_ENABLE,
    serial_irq_enable: PUC_VAL_ENABLE,
    sys_irq_flags_a: POR_VAL_SYS_FLAGS_A,
    serial_irq_flags: PUC_VAL_SERIAL_FLAGS,
    rdata: READ_FILL,
    pin_s1: 1'b1,
    pin_s2: 1'b1,
    pin_s3: 1'b1,
    power_up_clear: 1'b0,
    sys_reset: 1'b0,
    nmi_req: 1'b0,
    wdog_irq: 1'b0,
    rx_req: 1'b0,
    tx_req: 1'b0,
    ldr_dis: 1'b0,
    ldr_no_erase: 1'b0,
    sleep: 1'b0,
    boot_seen: 1'b0
  };

  sieb_state_t st_q;
  sieb_state_t st_d;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // code may run only from ram, boot, info and main flash
  function automatic logic is_fetch_illegal(input logic [15:0] a);
    logic bad;
    bad = 1'b0;
    if (a <= PERIPH_LAST) begin
      bad = 1'b1;
    end else if (a > RAM_LAST && a < BOOT_FIRST) begin
      bad = 1'b1;
    end else if (a > INFO_LAST && a < MAIN_FIRST) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  // software write first, then hardware sets on top of it
  function automatic logic [7:0] flag_update(
    input logic [7:0] cur,
    input logic wr,
    input logic [7:0] wdata,
    input logic [7:0] mask,
    input logic [7:0] set
  );
    logic [7:0] v;
    v = cur;
    if (wr) begin
      v = wdata;
    end
    v = (v | set) & mask;
    return v;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  logic sfr_hit;
  logic [3:0] sfr_ofs;
  logic wr_en_a;
  logic wr_en_s;
  logic wr_flag_a;
  logic wr_flag_s;
  logic pin_low;
  logic pin_reset;
  logic pin_fall;
  logic fetch_bad;
  logic wdog_reset;
  logic [7:0] set_a;
  logic [7:0] clr_a;
  logic [7:0] set_s;
  logic [7:0] nxt_flags_a;

  // address decode of the special register bytes
  assign sfr_hit = (sfr_req_i.addr >= SFR_BASE)
    && (sfr_req_i.addr <= SFR_LAST);
  assign sfr_ofs = sfr_req_i.addr[3:0];
  assign wr_en_a = sfr_req_i.wr && sfr_hit
    && (sfr_ofs == OFS_SYS_IRQ_ENABLE_A);
  assign wr_en_s = sfr_req_i.wr && sfr_hit
    && (sfr_ofs == OFS_SERIAL_IRQ_ENABLE);
  assign wr_flag_a = sfr_req_i.wr && sfr_hit
    && (sfr_ofs == OFS_SYS_IRQ_FLAGS_A);
  assign wr_flag_s = sfr_req_i.wr && sfr_hit
    && (sfr_ofs == OFS_SERIAL_IRQ_FLAGS);

  // reset and event sources, pin read only after the second stage
  assign pin_low = ~st_q.pin_s2;
  assign pin_reset = pin_low && !pin_nmi_sel_i;
  assign pin_fall = st_q.pin_s3 && !st_q.pin_s2 && pin_nmi_sel_i;
  assign fetch_bad = fetch_i && is_fetch_illegal(fetch_addr_i);
  assign wdog_reset = (wdog_i.overflow && wdog_i.reset_mode)
    || wdog_i.key_viol;

  // hardware set and clear terms of the system flags, and set terms of the serial flags
  always_comb begin
    set_a = 8'h00;
    clr_a = 8'h00;
    set_a[BIT_WDOG_FLAG] = wdog_reset;
    clr_a[BIT_WDOG_FLAG] = pin_reset;
    set_a[BIT_EXT_RESET_FLAG] = pin_reset;
    set_a[BIT_OSC_FAULT_FLAG] = osc_fault_i;
    set_a[BIT_PIN_NMI_FLAG] = pin_fall;
    set_s = {4'h0, unit_flag_set_i} & MASK_SERIAL_IRQ_FLAGS;
  end

  // register, request and boot word update
  always_comb begin
    st_d = st_q;
    nxt_flags_a = 8'h00;

    // pin synchroniser chain
    st_d.pin_s1 = rst_nmi_pin_n_i;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_s3 = st_q.pin_s2;

    // reset events are delivered with no enable involved
    st_d.sys_reset = fetch_bad || wdog_reset || pin_reset;
    st_d.power_up_clear = st_d.sys_reset;

    // enable registers, absent bits masked away
    if (wr_en_a) begin
      st_d.sys_irq_enable_a =
        sfr_req_i.wdata & MASK_SYS_IRQ_ENABLE_A;
    end
    if (wr_en_s) begin
      st_d.serial_irq_enable =
        sfr_req_i.wdata & MASK_SERIAL_IRQ_ENABLE;
    end

    // flags: clear by pin first, then write, set wins over both
    nxt_flags_a = st_q.sys_irq_flags_a & ~clr_a;
    st_d.sys_irq_flags_a = flag_update(nxt_flags_a, wr_flag_a,
      sfr_req_i.wdata, MASK_SYS_IRQ_FLAGS_A, set_a);
    st_d.serial_irq_flags = flag_update(st_q.serial_irq_flags,
      wr_flag_s, sfr_req_i.wdata, MASK_SERIAL_IRQ_FLAGS,
      set_s);

    // power-up clear reloads only the plain-valued bits
    if (st_q.power_up_clear) begin
      st_d.sys_irq_enable_a = PUC_VAL_ENABLE;
      st_d.serial_irq_enable = PUC_VAL_ENABLE;
      st_d.sys_irq_flags_a =
        (st_d.sys_irq_flags_a & ~PUC_MASK_SYS_FLAGS_A)
        | PUC_VAL_SYS_FLAGS_A;
      st_d.serial_irq_flags = PUC_VAL_SERIAL_FLAGS;
    end

    // read data, zero outside implemented bits and registers
    if (sfr_req_i.rd) begin
      st_d.rdata = READ_FILL;
      if (sfr_hit) begin
        unique case (sfr_ofs)
          OFS_SYS_IRQ_ENABLE_A: st_d.rdata = st_q.sys_irq_enable_a;
          OFS_SERIAL_IRQ_ENABLE: st_d.rdata = st_q.serial_irq_enable;
          OFS_SYS_IRQ_FLAGS_A: st_d.rdata = st_q.sys_irq_flags_a;
          OFS_SERIAL_IRQ_FLAGS: st_d.rdata = st_q.serial_irq_flags;
          default: st_d.rdata = READ_FILL;
        endcase
      end
    end

    // semi-maskable request, no global enable term
    st_d.nmi_req =
      (st_q.sys_irq_flags_a[BIT_PIN_NMI_FLAG]
        && st_q.sys_irq_enable_a[BIT_PIN_NMI_IRQ_EN])
      || (st_q.sys_irq_flags_a[BIT_OSC_FAULT_FLAG]
        && st_q.sys_irq_enable_a[BIT_OSC_FAULT_IRQ_EN])
      || (flash_viol_flag_i
        && st_q.sys_irq_enable_a[BIT_FLASH_VIOL_IRQ_EN]);

    // interval timer interrupt, dead in watchdog reset mode
    st_d.wdog_irq = st_q.sys_irq_flags_a[BIT_WDOG_FLAG]
      && st_q.sys_irq_enable_a[BIT_WDOG_IRQ_EN]
      && !wdog_i.reset_mode;

    // shared receive vector
    st_d.rx_req = st_q.serial_irq_flags[BIT_UNIT_A_RX]
      && st_q.serial_irq_enable[BIT_UNIT_A_RX];
    if (unit_b_mode_i == SIEB_MODE_I2C) begin
      st_d.rx_req = st_d.rx_req || (|i2c_stat_i);
    end else if (unit_b_mode_i == SIEB_MODE_SPI) begin
      st_d.rx_req = st_d.rx_req
        || (st_q.serial_irq_flags[BIT_UNIT_B_RX]
          && st_q.serial_irq_enable[BIT_UNIT_B_RX]);
    end

    // shared transmit vector
    st_d.tx_req = (st_q.serial_irq_flags[BIT_UNIT_A_TX]
        && st_q.serial_irq_enable[BIT_UNIT_A_TX])
      || (st_q.serial_irq_flags[BIT_UNIT_B_TX]
        && st_q.serial_irq_enable[BIT_UNIT_B_TX]);
    if (unit_b_mode_i == SIEB_MODE_I2C) begin
      st_d.tx_req = st_d.tx_req
        || (st_q.serial_irq_flags[BIT_UNIT_B_RX]
          && st_q.serial_irq_enable[BIT_UNIT_B_RX]);
    end

    // boot words caught after power-on and after each clear
    st_d.boot_seen = 1'b1;
    if (!st_q.boot_seen || st_q.power_up_clear) begin
      st_d.ldr_dis =
        (loader_security_word_i == LOADER_OFF_KEY);
      st_d.ldr_no_erase =
        (loader_security_word_i == LOADER_NO_ERASE_KEY);
      st_d.sleep =
        (reset_vector_i == BLANK_RESET_VECTOR);
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // power-on reset loads bracketed and plain values alike
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q <= ST_POR;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign sfr_rdata_o = st_q.rdata;
  assign sys_reset_o = st_q.sys_reset;
  assign power_up_clear_o = st_q.power_up_clear;
  assign nmi_req_o = st_q.nmi_req;
  assign wdog_irq_o = st_q.wdog_irq;
  assign rx_vec_req_o = st_q.rx_req;
  assign tx_vec_req_o = st_q.tx_req;
  assign loader_disabled_o = st_q.ldr_dis;
  assign loader_no_erase_o = st_q.ldr_no_erase;
  assign deepest_sleep_mode_o = st_q.sleep;

endmodule

// *** bench/sieb_top_sva.sv ***
// port assertions for the system interrupt bank
// assumes one core clock and the synchronous low reset of sieb_top
`timescale 1ns/1ps
module sieb_top_sva
  import sieb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire sieb_sfr_req_t sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic fetch_i,
  input wire logic [15:0] fetch_addr_i,
  input wire sieb_wdog_ev_t wdog_i,
  input wire logic rst_nmi_pin_n_i,
  input wire logic pin_nmi_sel_i,
  input wire logic [15:0] loader_security_word_i,
  input wire logic [15:0] reset_vector_i,
  input wire logic sys_reset_o,
  input wire logic power_up_clear_o,
  input wire logic wdog_irq_o,
  input wire logic loader_disabled_o,
  input wire logic loader_no_erase_o,
  input wire logic deepest_sleep_mode_o
);
  // ****************************************************************
  // helpers and properties
  // ****************************************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic rstn_q;
  logic cap;
  // boot words are taken after reset release and on each clear
  always_ff @(posedge core_clk_i) begin
    rstn_q <= rstn_i;
  end
  assign cap = (rstn_i && !rstn_q) || power_up_clear_o;
  // pin held low in reset mode long enough to pass the sync
  sequence s_pin_held;
    (!pin_nmi_sel_i && !rst_nmi_pin_n_i) [*5];
  endsequence
  sequence s_bad_fetch;
    fetch_i && (fetch_addr_i <= PERIPH_LAST ||
      (fetch_addr_i > RAM_LAST && fetch_addr_i < BOOT_FIRST));
  endsequence

  a_bad_fetch: assert property (s_bad_fetch |=> sys_reset_o)
    else $error("fetch outside code gave no reset");
  a_pin_reset: assert property (s_pin_held |-> sys_reset_o)
    else $error("reset pin gave no reset");
  a_wdog_reset: assert property (
    wdog_i.overflow && wdog_i.reset_mode |=> sys_reset_o)
    else $error("watchdog overflow gave no reset");
  a_clear_tracks: assert property (
    power_up_clear_o == sys_reset_o)
    else $error("power-up clear differs from reset");
  a_wdog_masked: assert property (
    wdog_i.reset_mode [*2] |-> !wdog_irq_o)
    else $error("watchdog irq in reset mode");
  a_loader_off: assert property (
    cap && loader_security_word_i == LOADER_OFF_KEY
    |=> loader_disabled_o)
    else $error("loader not disabled");
  a_no_erase: assert property (
    cap && loader_security_word_i == LOADER_NO_ERASE_KEY
    |=> loader_no_erase_o && !loader_disabled_o)
    else $error("erase block wrong");
  a_blank_vector: assert property (
    cap |=> deepest_sleep_mode_o ==
      ($past(reset_vector_i) == BLANK_RESET_VECTOR))
    else $error("sleep output wrong");
  a_gap_reads: assert property (
    sfr_req_i.rd && sfr_req_i.addr[15:2] != 14'h0
    |=> sfr_rdata_o == READ_FILL)
    else $error("gap read not zero");
endmodule

bind sieb_top sieb_top_sva u_sva (
  .core_clk_i,
  .rstn_i,
  .sfr_req_i,
  .sfr_rdata_o,
  .fetch_i,
  .fetch_addr_i,
  .wdog_i,
  .rst_nmi_pin_n_i,
  .pin_nmi_sel_i,
  .loader_security_word_i,
  .reset_vector_i,
  .sys_reset_o,
  .power_up_clear_o,
  .wdog_irq_o,
  .loader_disabled_o,
  .loader_no_erase_o,
  .deepest_sleep_mode_o
);

// *** bench/sieb_cpu_model.sv ***
// core side model issuing byte reads and writes of the registers
// assumes callers enter its tasks just after a falling clock edge
`timescale 1ns/1ps
module sieb_cpu_model
  import sieb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [7:0] sfr_rdata_i,
  output sieb_sfr_req_t sfr_req_o
);
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  initial sfr_req_o = '0;
  // one-cycle write, then the bus shows inverted leftovers
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    sfr_req_o = '{1'b0, 1'b1, a, d};
    @(negedge core_clk_i);
    sfr_req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // one-cycle read, data taken a cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    sfr_req_o = '{1'b1, 1'b0, a, 8'h00};
    @(negedge core_clk_i);
    d = sfr_rdata_i;
    sfr_req_o = '{1'b0, 1'b0, ~a, 8'hFF};
  endtask
endmodule

// *** bench/system_irq_enable_flag_bank_test.sv ***
// self-checking bench for the system interrupt bank
// assumes sieb_top, its checker and the core model are compiled
`timescale 1ns/1ps
module system_irq_enable_flag_bank_test import sieb_pkg::*;;
  // ****************************************************************
  // stimulus and checks
  // ****************************************************************
  logic clk = 1'b0, rstn = 1'b0, fetch = 1'b0, osc = 1'b0;
  logic pin = 1'b1, sel = 1'b0, fv = 1'b0, power_up_clear;
  logic [15:0] fetch_addr = 16'h0000, lsw = 16'hAA55;
  logic [15:0] rvec = 16'hFFFF;
  logic [3:0] uset = 4'h0;
  sieb_wdog_ev_t wdog = '0;
  sieb_ub_mode_t mode = SIEB_MODE_UART;
  sieb_i2c_stat_t i2c = '0;
  sieb_sfr_req_t req;
  logic [7:0] rdata;
  logic sys_rst, nmi_req, wdog_irq, rxv, txv, ld_off, ld_ne, sleep;
  int err_count = 0, checks_done = 0, cyc = 0;
  logic [15:0] row [6] = '{16'h0400, 16'h0442, 16'h0481, 16'h00A2,
    16'h0801, 16'h0841};
  logic [15:0] fa [4] = '{16'hE000, 16'h0100, 16'h0500, 16'h1000};
  logic [3:0] fa_bad = 4'b0110;

  always #2 clk = ~clk;

  sieb_cpu_model cpu (.core_clk_i(clk), .sfr_rdata_i(rdata),
    .sfr_req_o(req));
  sieb_top dut (.core_clk_i(clk), .rstn_i(rstn), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .fetch_i(fetch), .fetch_addr_i(fetch_addr),
    .wdog_i(wdog), .osc_fault_i(osc), .flash_viol_flag_i(fv),
    .rst_nmi_pin_n_i(pin), .pin_nmi_sel_i(sel),
    .unit_flag_set_i(uset), .unit_b_mode_i(mode), .i2c_stat_i(i2c),
    .loader_security_word_i(lsw), .reset_vector_i(rvec),
    .sys_reset_o(sys_rst), .power_up_clear_o(power_up_clear), .nmi_req_o(nmi_req),
    .wdog_irq_o(wdog_irq), .rx_vec_req_o(rxv), .tx_vec_req_o(txv),
    .loader_disabled_o(ld_off), .loader_no_erase_o(ld_ne),
    .deepest_sleep_mode_o(sleep));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd(a, d);
    chk8(d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    tick(16);
    rstn = 1'b1;
    tick(2);
    rd_chk(16'h0, 8'h00);
    rd_chk(16'h1, 8'h00);
    rd_chk(16'h2, 8'h06);
    rd_chk(16'h3, 8'h0A);
    chk1(ld_off, 1'b1);
    chk1(sleep, 1'b1);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) cpu.wr(i[15:0], 8'hFF);
    rd_chk(16'h0, 8'h33);
    rd_chk(16'h1, 8'h0F);
    rd_chk(16'h2, 8'h1F);
    rd_chk(16'h3, 8'h0F);
    rd_chk(16'h5, 8'h00);
    rd_chk(16'h20, 8'h00);
    chk1(wdog_irq, 1'b1);
    chk1(nmi_req, 1'b1);
    wdog.reset_mode = 1'b1;
    tick(3);
    chk1(wdog_irq, 1'b0);
    $display("test bit masks done");
    cpu.wr(16'h1, 8'h0C);
    foreach (row[i]) begin
      mode = sieb_ub_mode_t'(row[i][7:6]);
      i2c = row[i][5:2];
      cpu.wr(16'h3, row[i][15:8]);
      tick(3);
      chk1(rxv, row[i][1]);
      chk1(txv, row[i][0]);
    end
    i2c = '0;
    uset = 4'h1;
    cpu.wr(16'h3, 8'h00);
    uset = 4'h0;
    rd_chk(16'h3, 8'h01);
    $display("test serial vectors done");
    cpu.wr(16'h2, 8'h00);
    cpu.wr(16'h0, 8'h10);
    sel = 1'b1;
    tick(3);
    pin = 1'b0;
    osc = 1'b1;
    tick(1);
    osc = 1'b0;
    tick(4);
    pin = 1'b1;
    chk1(nmi_req, 1'b1);
    rd_chk(16'h2, 8'h12);
    cpu.wr(16'h0, 8'h00);
    tick(3);
    chk1(nmi_req, 1'b0);
    fv = 1'b1;
    cpu.wr(16'h0, 8'h20);
    tick(3);
    chk1(nmi_req, 1'b1);
    fv = 1'b0;
    tick(3);
    chk1(nmi_req, 1'b0);
    $display("test nmi done");
    cpu.wr(16'h0, 8'h33);
    cpu.wr(16'h2, 8'h10);
    cpu.wr(16'h3, 8'h05);
    lsw = 16'h0000;
    rvec = 16'h1234;
    wdog.overflow = 1'b1;
    tick(1);
    wdog.overflow = 1'b0;
    chk1(sys_rst, 1'b1);
    chk1(power_up_clear, 1'b1);
    tick(3);
    rd_chk(16'h0, 8'h00);
    rd_chk(16'h2, 8'h03);
    rd_chk(16'h3, 8'h0A);
    chk1(ld_off, 1'b0);
    chk1(ld_ne, 1'b1);
    chk1(sleep, 1'b0);
    $display("test watchdog clear done");
    foreach (fa[i]) begin
      fetch_addr = fa[i];
      fetch = 1'b1;
      tick(1);
      fetch = 1'b0;
      chk1(sys_rst, fa_bad[i]);
      tick(3);
    end
    $display("test fetch done");
    sel = 1'b0;
    tick(2);
    pin = 1'b0;
    tick(6);
    pin = 1'b1;
    tick(6);
    rd_chk(16'h2, 8'h0A);
    $display("test reset pin done");
    wrap_up();
  end
endmodule
